// >>> dv/ptw_mem_model.sv
// memory model holding translation tables for the walker bench
`default_nettype none

module ptw_mem_model
(
    input wire logic core_clk,
    input wire logic mem_req_valid,
    input wire logic [51:0] mem_req_addr,
    output logic mem_req_ready,
    output logic mem_rsp_valid,
    output logic [63:0] mem_rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] tbl [logic [51:0]];
    logic slow = 1'b0;
    logic busy = 1'b0;
    logic [51:0] addr_q = 52'h0;
    int cnt = 0;
    initial
    begin
        mem_req_ready = 1'b0;
        mem_rsp_valid = 1'b0;
        mem_rsp_data = 64'h0;
    end
    // one fetch outstanding, one whole 64-bit entry back
    // data toggles outside a response so stale values never look valid
    always @(posedge core_clk)
    begin
        mem_req_ready <= slow ? ~mem_req_ready : 1'b1;
        if (busy && cnt == 0)
        begin
            busy <= 1'b0;
            mem_rsp_valid <= 1'b1;
            mem_rsp_data <= tbl.exists(addr_q) ? tbl[addr_q] : 64'h0;
        end
        else
        begin
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= ~mem_rsp_data;
            if (busy)
                cnt <= cnt - 1;
            else if (mem_req_valid && mem_req_ready)
            begin
                busy <= 1'b1;
                addr_q <= mem_req_addr;
                cnt <= slow ? 3 : 0;
            end
        end
    end
endmodule // ptw_mem_model

`default_nettype wire

// >>> dv/ptw_walker_chk.sv
// checker: port-level properties of the page translation walker
`include "ptw_consts.svh"
`default_nettype none

module ptw_walker_chk
    import ptw_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic xl_req_valid,
    input wire logic [63:0] xl_req_vaddr,
    input wire logic [2:0] xl_req_len,
    input wire logic xl_req_stack,
    input wire logic xl_req_ready,
    input wire logic xl_rsp_valid,
    input wire logic [51:0] xl_rsp_paddr,
    input wire logic [1:0] xl_rsp_page,
    input wire logic [1:0] xl_rsp_fault,
    input wire logic mem_req_valid,
    input wire logic [51:0] mem_req_addr,
    input wire logic mem_req_writethrough,
    input wire logic mem_req_uncacheable,
    input wire logic mem_req_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // shadow of mode and root, rebuilt from register writes
    // ****
    logic pae_r;
    logic long_r;
    logic [63:0] root_r;
    logic take;
    logic canon_first;
    logic canon;
    logic [63:0] last_va;
    logic [8:0] top_idx;
    logic [31:0] lo_va;
    assign take = xl_req_valid && xl_req_ready;
    assign last_va = xl_req_vaddr + {61'h0, xl_req_len};
    assign canon_first = &xl_req_vaddr[63:47] || ~|xl_req_vaddr[63:47];
    assign canon = canon_first && (&last_va[63:47] || ~|last_va[63:47]);
    assign top_idx = xl_req_vaddr[47:39];
    assign lo_va = xl_req_vaddr[31:0];
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pae_r <= 1'b0;
            long_r <= 1'b0;
        end
        else if (reg_wr && reg_addr == `PTW_OFS_CTRL)
        begin
            pae_r <= reg_wdata[`PTW_CTRL_PAE];
            long_r <= reg_wdata[`PTW_CTRL_LME] && reg_wdata[`PTW_CTRL_PAE];
        end
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            root_r <= 64'h0;
        else if (reg_wr && reg_addr == `PTW_OFS_ROOT_LO)
            root_r[31:0] <= reg_wdata;
        else if (reg_wr && reg_addr == `PTW_OFS_ROOT_HI)
            root_r[63:32] <= reg_wdata;
    end
    // ****
    // properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_fetch_stall;
        mem_req_valid && !mem_req_ready;
    endsequence
    sequence s_bad_take;
        take && long_r && !canon_first;
    endsequence
    sequence s_good_take;
        take && long_r && canon;
    endsequence
    sequence s_top_fetch;
        mem_req_valid && mem_req_writethrough == root_r[`PTW_ROOT_WT]
        && mem_req_uncacheable == root_r[`PTW_ROOT_UC]
        && mem_req_addr == {root_r[51:12], $past(top_idx), 3'h0};
    endsequence
    chk_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    chk_root_read_back: assert property (
        $past(reg_rd) && $past(reg_addr) == `PTW_OFS_ROOT_LO
        |-> reg_rdata == root_r[31:0])
        else $error("root pointer low word reads wrong");
    chk_fetch_hold: assert property (
        s_fetch_stall |=> mem_req_valid && $stable(mem_req_addr))
        else $error("fetch dropped or changed before ready");
    chk_entry_align: assert property (
        mem_req_valid |-> mem_req_addr[2:0] == 3'h0)
        else $error("entry address not a multiple of eight");
    chk_busy_refuse: assert property (
        mem_req_valid |-> !xl_req_ready)
        else $error("request accepted during a walk");
    chk_rsp_one_cycle: assert property (
        xl_rsp_valid |=> !xl_rsp_valid && xl_req_ready)
        else $error("response not a single pulse back to idle");
    chk_canon_fault: assert property (
        s_bad_take |=> xl_rsp_valid && xl_rsp_page == PG_NONE
        && xl_rsp_fault == ($past(xl_req_stack) ? FLT_SS : FLT_GP))
        else $error("non-canonical reference not faulted");
    chk_top_fetch: assert property (
        s_good_take |=> s_top_fetch)
        else $error("first fetch address or attributes wrong");
    chk_paging_off: assert property (
        take && !pae_r |=> xl_rsp_valid && xl_rsp_page == PG_NONE
        && xl_rsp_paddr == {20'h0, $past(lo_va)})
        else $error("untranslated response wrong");
endmodule // ptw_walker_chk

bind ptw_walker ptw_walker_chk u_chk (.core_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xl_req_valid, .xl_req_vaddr,
    .xl_req_len, .xl_req_stack, .xl_req_ready, .xl_rsp_valid, .xl_rsp_paddr,
    .xl_rsp_page, .xl_rsp_fault, .mem_req_valid, .mem_req_addr,
    .mem_req_writethrough, .mem_req_uncacheable, .mem_req_ready);

`default_nettype wire

// >>> dv/tb_page_translation_walker.sv
// self-checking testbench of the page translation walker
`include "ptw_consts.svh"
`default_nettype none

module tb_page_translation_walker
    import ptw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic xl_req_valid = 1'b0;
    logic [63:0] xl_req_vaddr = 64'h0;
    logic [2:0] xl_req_len = 3'h0;
    logic xl_req_stack = 1'b0;
    logic xl_req_ready, xl_rsp_valid, mem_req_valid, mem_req_writethrough;
    logic [51:0] xl_rsp_paddr, mem_req_addr;
    logic [1:0] xl_rsp_page, xl_rsp_fault;
    logic mem_req_uncacheable, mem_req_ready, mem_rsp_valid;
    logic [63:0] mem_rsp_data, root, va, x;
    logic [51:0] epa;
    int seed = 7363;
    int errors = 0;
    int comparisons = 0;
    int k;
    always #2 core_clk = ~core_clk;
    ptw_walker u_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .xl_req_valid, .xl_req_vaddr, .xl_req_len,
        .xl_req_stack, .xl_req_ready, .xl_rsp_valid, .xl_rsp_paddr,
        .xl_rsp_page, .xl_rsp_fault, .mem_req_valid, .mem_req_addr,
        .mem_req_writethrough, .mem_req_uncacheable, .mem_req_ready,
        .mem_rsp_valid, .mem_rsp_data);
    ptw_mem_model u_mem (.core_clk, .mem_req_valid, .mem_req_addr,
        .mem_req_ready, .mem_rsp_valid, .mem_rsp_data);
    // ****
    // shared tasks
    // ****
    function automatic logic [63:0] rnd();
        return {$random(seed), $random(seed)};
    endfunction
    task automatic check(input string n, input logic [63:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [7:0] a,
        input logic [31:0] m, e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(n, {32'h0, reg_rdata & m}, {32'h0, e});
    endtask
    // software zeroes reserved and unused root bits
    task automatic setroot(input logic [63:0] r);
        root = r;
        wr(`PTW_OFS_ROOT_LO, r[31:0]);
        wr(`PTW_OFS_ROOT_HI, r[63:32]);
    endtask
    // tables from level f to l; bit 7 set at a non-leaf end level
    task automatic build(input logic [63:0] v, input int f, l);
        logic [51:0] a, b, m;
        logic [63:0] e;
        a = f == 0 ? {root[51:12], 12'h0} : {20'h0, root[31:5], 5'h0};
        b = 52'h0;
        for (int i = f; i <= l; i++)
        begin
            a = a + {40'h0, v[47 - 9 * i -: 9], 3'h0};
            e = rnd();
            b = {e[51:12], 12'h0};
            e = {12'h0, b[51:12], 12'h001};
            if (i == l && l < 3)
                e[`PTW_ENT_PS] = 1'b1;
            u_mem.tbl[a] = e;
            a = b;
        end
        m = (52'h1 << (12 + 9 * (3 - l))) - 52'h1;
        epa = (b & ~m) | (v[51:0] & m);
    endtask
    task automatic xlate(input logic [63:0] v, input logic [2:0] len,
        input logic s, input logic [1:0] pg, flt);
        int n;
        n = 0;
        @(posedge core_clk);
        xl_req_valid <= 1'b1;
        xl_req_vaddr <= v;
        xl_req_len <= len;
        xl_req_stack <= s;
        #1 while (xl_req_ready !== 1'b1 && n < 50)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        @(posedge core_clk);
        xl_req_valid <= 1'b0;
        #1 n = 0;
        while (xl_rsp_valid !== 1'b1 && n < 300)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        check("rsp valid", {63'h0, xl_rsp_valid}, 64'h1);
        check("page", {62'h0, xl_rsp_page}, {62'h0, pg});
        check("fault", {62'h0, xl_rsp_fault}, {62'h0, flt});
        if (flt == FLT_NONE)
            check("paddr", {12'h0, xl_rsp_paddr}, {12'h0, epa});
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    initial
    begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdchk("root reset", `PTW_OFS_ROOT_HI, 32'hffffffff, 32'h0);
        rdchk("ctrl reset", `PTW_OFS_CTRL, 32'h7, 32'h0);
        wr(8'h20, 32'h5a5a_a5a5);
        rdchk("unmapped", 8'h20, 32'hffffffff, 32'h0);
        for (k = 0; k < 3; k++)
        begin
            va = rnd();
            epa = {20'h0, va[31:0]};
            xlate(va, 3'h0, 1'b0, PG_NONE, FLT_NONE);
        end
        wr(`PTW_OFS_CTRL, 32'h4);
        rdchk("long without ext", `PTW_OFS_STATUS, 32'h5, 32'h1);
        wr(`PTW_OFS_STATUS, 32'h1);
        rdchk("fault cleared", `PTW_OFS_STATUS, 32'h1, 32'h0);
        wr(`PTW_OFS_CTRL, 32'h1);
        x = rnd();
        setroot({32'h0, x[31:5], 5'h0});
        for (k = 0; k < 3; k++)
        begin
            x = rnd();
            va = {32'h0, x[31:0]};
            build(va, 1, 2);
            xlate(va, 3'h0, 1'b0, PG_2M, FLT_NONE);
        end
        x = rnd();
        setroot({12'h0, x[51:12], 7'h0, x[4:3], 3'h0});
        // pse set in the second half must change nothing
        for (k = 0; k < 12; k++)
        begin
            if (k % 6 == 0)
                wr(`PTW_OFS_CTRL, k < 6 ? 32'h5 : 32'h7);
            u_mem.slow = k >= 6;
            x = rnd();
            va = k == 0 ? 64'h0000_7fff_ffff_f000 : {{16{x[47]}}, x[47:0]};
            build(va, 0, 3 - k % 3);
            xlate(va, x[50:48], 1'b0, 2'(k % 3), FLT_NONE);
        end
        rdchk("long active", `PTW_OFS_STATUS, 32'h4, 32'h4);
        for (k = 0; k < 4; k++)
        begin
            x = rnd();
            va = {~{16{x[47]}}, x[47:0]};
            xlate(va, 3'h0, k[0], PG_NONE, k[0] ? FLT_SS : FLT_GP);
        end
        xlate(64'h0000_8000_0000_0000, 3'h0, 1'b0, PG_NONE, FLT_GP);
        xlate(64'h0000_7fff_ffff_fffc, 3'h7, 1'b1, PG_NONE, FLT_SS);
        u_mem.tbl[{root[51:12], 9'h1ff, 3'h0}] = 64'h0;
        va = 64'hffff_ff80_0000_0000;
        xlate(va, 3'h0, 1'b0, PG_NONE, FLT_NOT_PRESENT);
        results();
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        results();
    end
endmodule // tb_page_translation_walker

`default_nettype wire

// >>> rtl/ptw_canon_check.sv
// canonical form check of the first and last byte of a reference
`include "ptw_consts.svh"
`default_nettype none

module ptw_canon_check
    import ptw_pkg::*;
(
    input wire logic [63:0] vaddr,
    input wire logic [2:0] len,
    input wire logic long_mode,
    output logic canonical
);
    logic [63:0] last_addr;

    // ************************************************************
    // sign extension test
    // ************************************************************
    // bits from the top implemented bit up to bit 63 must all agree
    function automatic logic is_canon(input logic [63:0] a);
        logic [64-`PTW_VA_BITS:0] top;
        top = a[63:`PTW_VA_BITS-1];
        is_canon = (&top) | ~(|top);
    endfunction

    // the reference is contiguous, so its two end bytes decide it
    assign last_addr = vaddr + {61'h0, len};
    assign canonical = ~long_mode |
        (is_canon(vaddr) & is_canon(last_addr));
endmodule // ptw_canon_check

`default_nettype wire

// >>> rtl/ptw_consts.svh
// constants for the page translation walker: offsets, fields, resets
`ifndef PTW_CONSTS_SVH
`define PTW_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses on the register port)
// ****************************************************************
`define PTW_OFS_ROOT_LO 8'h00
`define PTW_OFS_ROOT_HI 8'h04
`define PTW_OFS_CTRL 8'h08
`define PTW_OFS_STATUS 8'h0c
`define PTW_OFS_PA_LO 8'h10
`define PTW_OFS_PA_HI 8'h14

// ****************************************************************
// control and status fields
// ****************************************************************
`define PTW_CTRL_PAE 0
`define PTW_CTRL_PSE 1
`define PTW_CTRL_LME 2
`define PTW_STS_ACT_FAULT 0
`define PTW_STS_BUSY 1
`define PTW_STS_LONG 2
`define PTW_STS_PAGE_LSB 4
`define PTW_STS_FAULT_LSB 8

// ****************************************************************
// reset values
// ****************************************************************
`define PTW_ROOT_RESET 64'h0000_0000_0000_0000
`define PTW_CTRL_BIT_RESET 1'b0
`define PTW_PA_RESET 52'h0_0000_0000_0000

// ****************************************************************
// root pointer and table entry fields
// ****************************************************************
`define PTW_ROOT_WT 3
`define PTW_ROOT_UC 4
`define PTW_ENT_PRESENT 0
`define PTW_ENT_WT 3
`define PTW_ENT_UC 4
`define PTW_ENT_PS 7

// ****************************************************************
// address geometry
// ****************************************************************
`define PTW_VA_BITS 48
`define PTW_PA_BITS 52
`define PTW_GIG_PAGES 1'b1

`endif

// >>> rtl/ptw_pkg.sv
// types shared by the page translation walker
`default_nettype none

package ptw_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_RESP}
        ptw_state_type;
    typedef enum logic [1:0] {LVL_TOP, LVL_PTR, LVL_DIR, LVL_LEAF}
        ptw_level_type;
    typedef enum logic [1:0] {PG_4K, PG_2M, PG_1G, PG_NONE} ptw_page_type;
    typedef enum logic [1:0] {FLT_NONE, FLT_GP, FLT_SS, FLT_NOT_PRESENT}
        ptw_fault_type;
endpackage

`default_nettype wire

// >>> rtl/ptw_walker.sv
// page translation walker: control registers and table walk engine
//
// Local design decisions: the strobed register port and the register offsets.
`include "ptw_consts.svh"
`default_nettype none

module ptw_walker
    import ptw_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic xl_req_valid,
    input wire logic [63:0] xl_req_vaddr,
    input wire logic [2:0] xl_req_len,
    input wire logic xl_req_stack,
    output logic xl_req_ready,
    output logic xl_rsp_valid,
    output logic [51:0] xl_rsp_paddr,
    output logic [1:0] xl_rsp_page,
    output logic [1:0] xl_rsp_fault,
    output logic mem_req_valid,
    output logic [51:0] mem_req_addr,
    output logic mem_req_writethrough,
    output logic mem_req_uncacheable,
    input wire logic mem_req_ready,
    input wire logic mem_rsp_valid,
    input wire logic [63:0] mem_rsp_data
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    // ************************************************************
    // declarations
    // ************************************************************
    logic [63:0] root_r;
    logic pae_r;
    logic pse_r;
    logic lme_r;
    logic act_fault_r;
    ptw_state_type state_r;
    ptw_level_type lvl_r;
    logic [63:0] va_r;
    logic long_r;
    logic [51:0] base_r;
    logic wt_r;
    logic uc_r;
    logic [51:0] paddr_r;
    ptw_page_type page_r;
    ptw_fault_type fault_r;
    logic canonical;
    logic [8:0] idx;
    logic [63:0] ent;
    logic wr_ctrl;
    logic wr_status;
    logic act_attempt;

    // ************************************************************
    // register writes
    // ************************************************************
    assign wr_ctrl = reg_wr && (reg_addr == `PTW_OFS_CTRL);
    assign wr_status = reg_wr && (reg_addr == `PTW_OFS_STATUS);
    // long mode asked for while the extension stays off
    assign act_attempt = wr_ctrl && reg_wdata[`PTW_CTRL_LME] &&
        !reg_wdata[`PTW_CTRL_PAE];

    // reserved and unimplemented root bits are stored as written
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            root_r <= `PTW_ROOT_RESET;
        else if (reg_wr && reg_addr == `PTW_OFS_ROOT_LO)
            root_r[31:0] <= reg_wdata;
        else if (reg_wr && reg_addr == `PTW_OFS_ROOT_HI)
            root_r[63:32] <= reg_wdata;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pae_r <= `PTW_CTRL_BIT_RESET;
            pse_r <= `PTW_CTRL_BIT_RESET;
            lme_r <= `PTW_CTRL_BIT_RESET;
        end
        else if (wr_ctrl)
        begin
            pae_r <= reg_wdata[`PTW_CTRL_PAE];
            pse_r <= reg_wdata[`PTW_CTRL_PSE];
            // long mode never becomes active without the extension
            lme_r <= reg_wdata[`PTW_CTRL_LME] &
                reg_wdata[`PTW_CTRL_PAE];
        end
    end

    // sticky; a new refused activation beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            act_fault_r <= 1'b0;
        else if (act_attempt)
            act_fault_r <= 1'b1;
        else if (wr_status && reg_wdata[`PTW_STS_ACT_FAULT])
            act_fault_r <= 1'b0;
    end

    // ************************************************************
    // request checks and entry address
    // ************************************************************
    ptw_canon_check u_canon (
        .vaddr(xl_req_vaddr),
        .len(xl_req_len),
        .long_mode(lme_r),
        .canonical(canonical)
    );

    // table index for a level; legacy pointer table has four entries
    function automatic logic [8:0] index_of(input ptw_level_type lvl,
                                            input logic [63:0] va,
                                            input logic long_m);
        case (lvl)
            LVL_TOP: index_of = va[47:39];
            LVL_PTR: index_of = long_m ? va[38:30] :
                {7'h00, va[31:30]};
            LVL_DIR: index_of = va[29:21];
            LVL_LEAF: index_of = va[20:12];
            default: index_of = 9'h000;
        endcase
    endfunction

    assign idx = index_of(lvl_r, va_r, long_r);
    assign mem_req_addr = base_r + {40'h0, idx, 3'h0};
    assign mem_req_valid = (state_r == ST_ISSUE);
    assign mem_req_writethrough = wt_r;
    assign mem_req_uncacheable = uc_r;
    assign xl_req_ready = (state_r == ST_IDLE);
    assign xl_rsp_valid = (state_r == ST_RESP);
    assign xl_rsp_paddr = paddr_r;
    assign xl_rsp_page = page_r;
    assign xl_rsp_fault = fault_r;
    assign ent = mem_rsp_data;

    // ************************************************************
    // walk engine
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            lvl_r <= LVL_TOP;
            va_r <= 64'h0;
            long_r <= 1'b0;
            base_r <= 52'h0;
            wt_r <= 1'b0;
            uc_r <= 1'b0;
            paddr_r <= `PTW_PA_RESET;
            page_r <= PG_NONE;
            fault_r <= FLT_NONE;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (xl_req_valid)
                    begin
                        // mode is latched so a mid-walk write cannot mix
                        va_r <= xl_req_vaddr;
                        long_r <= lme_r;
                        fault_r <= FLT_NONE;
                        wt_r <= root_r[`PTW_ROOT_WT];
                        uc_r <= root_r[`PTW_ROOT_UC];
                        if (!pae_r)
                        begin
                            // extension paging off: low 32 address bits pass through, zero extended
                            paddr_r <= {20'h0, xl_req_vaddr[31:0]};
                            page_r <= PG_NONE;
                            state_r <= ST_RESP;
                        end
                        else if (!canonical)
                        begin
                            fault_r <= xl_req_stack ? FLT_SS :
                                FLT_GP;
                            page_r <= PG_NONE;
                            state_r <= ST_RESP;
                        end
                        else if (lme_r)
                        begin
                            base_r <= {root_r[51:12], 12'h000};
                            lvl_r <= LVL_TOP;
                            state_r <= ST_ISSUE;
                        end
                        else
                        begin
                            // legacy pointer table is 32-byte aligned
                            base_r <= {20'h0, root_r[31:5], 5'h00};
                            lvl_r <= LVL_PTR;
                            state_r <= ST_ISSUE;
                        end
                    end
                end
                ST_ISSUE:
                begin
                    if (mem_req_ready)
                        state_r <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (mem_rsp_valid)
                    begin
                        // next fetch takes its caching from this entry
                        wt_r <= ent[`PTW_ENT_WT];
                        uc_r <= ent[`PTW_ENT_UC];
                        base_r <= {ent[51:12], 12'h000};
                        state_r <= ST_ISSUE;
                        if (!ent[`PTW_ENT_PRESENT])
                        begin
                            fault_r <= FLT_NOT_PRESENT;
                            page_r <= PG_NONE;
                            state_r <= ST_RESP;
                        end
                        else
                        begin
                            case (lvl_r)
                                LVL_TOP:
                                    lvl_r <= LVL_PTR;
                                LVL_PTR:
                                begin
                                    if (long_r && `PTW_GIG_PAGES &&
                                        ent[`PTW_ENT_PS])
                                    begin
                                        paddr_r <= {ent[51:30],
                                            va_r[29:0]};
                                        page_r <= PG_1G;
                                        state_r <= ST_RESP;
                                    end
                                    else
                                        lvl_r <= LVL_DIR;
                                end
                                LVL_DIR:
                                begin
                                    // size bit alone decides; pse unused
                                    if (ent[`PTW_ENT_PS])
                                    begin
                                        paddr_r <= {ent[51:21],
                                            va_r[20:0]};
                                        page_r <= PG_2M;
                                        state_r <= ST_RESP;
                                    end
                                    else
                                        lvl_r <= LVL_LEAF;
                                end
                                LVL_LEAF:
                                begin
                                    paddr_r <= {ent[51:12],
                                        va_r[11:0]};
                                    page_r <= PG_4K;
                                    state_r <= ST_RESP;
                                end
                                default:
                                    state_r <= ST_RESP;
                            endcase
                        end
                    end
                end
                ST_RESP:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************
    // unmapped offsets read as zero rather than stalling the master
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `PTW_OFS_ROOT_LO: reg_rdata <= root_r[31:0];
                `PTW_OFS_ROOT_HI: reg_rdata <= root_r[63:32];
                `PTW_OFS_CTRL:
                begin
                    reg_rdata <= 32'h0000_0000;
                    reg_rdata[`PTW_CTRL_PAE] <= pae_r;
                    reg_rdata[`PTW_CTRL_PSE] <= pse_r;
                    reg_rdata[`PTW_CTRL_LME] <= lme_r;
                end
                `PTW_OFS_STATUS:
                begin
                    reg_rdata <= 32'h0000_0000;
                    reg_rdata[`PTW_STS_ACT_FAULT] <= act_fault_r;
                    reg_rdata[`PTW_STS_BUSY] <= (state_r != ST_IDLE);
                    reg_rdata[`PTW_STS_LONG] <= lme_r;
                    reg_rdata[`PTW_STS_PAGE_LSB +: 2] <= page_r;
                    reg_rdata[`PTW_STS_FAULT_LSB +: 2] <= fault_r;
                end
                `PTW_OFS_PA_LO: reg_rdata <= paddr_r[31:0];
                `PTW_OFS_PA_HI: reg_rdata <= {12'h000, paddr_r[51:32]};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end
endmodule // ptw_walker

`default_nettype wire
